/* File: pkg/rtc_flags_pkg.sv */
// Package: register map, field positions and carriers of the RTC flag block
package rtc_flags_pkg;

   // ************************************************************
   // Register word indices (byte address = index * 4)
   // ************************************************************
   localparam logic [3:0] mode_idx = 4'h0;    // Mode: masks, clock on, day mode
   localparam logic [3:0] status_idx = 4'h1;  // Status: valid, alarm, periodic
   localparam logic [3:0] irq_stat_idx = 4'h2; // Sticky event status, read only
   localparam logic [3:0] irq_en_idx = 4'h3;  // Event interrupt enable
   localparam logic [3:0] irq_clr_idx = 4'h4; // Event clear, write only
   localparam logic [3:0] alarm_idx = 4'h5;   // Example blocked register: alarm day

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int mode_on_bit = 7;
   localparam int mode_daycmp_bit = 3;
   localparam int mode_alarm_msk_bit = 1;
   localparam int mode_per_msk_bit = 0;
   localparam int stat_valid_bit = 7;
   localparam int stat_alarm_bit = 1;
   localparam int stat_per_bit = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] mode_rst = 8'h00;
   localparam logic [7:0] status_rst = 8'h00;
   localparam logic [1:0] irq_rst = 2'h0;
   localparam logic [4:0] alarm_day_rst = 5'h00;

   // Wishbone request carrier
   typedef struct packed {
      logic [3:0] idx;
      logic we;
      logic sel0;
      logic [7:0] dat;
   } wb_req_s;

   // Event carrier from the counting core
   typedef struct packed {
      logic alarm;
      logic second;
   } rtc_evt_s;

endpackage

/* File: logic/rtc_flags.sv */
// RTC status, mask and interrupt flag logic behind a classic Wishbone slave
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// Summary of operation
// - Periodic mask zero, its reset value, suppresses periodic interrupt.
// - Periodic mask at one raises a periodic interrupt every RTC second.
// - Hard reset clears the validity flag to zero.
// - Validity zero means clock data invalid, one means valid.
// - Alarm match sets sticky alarm pending flag in status bit 1.
// - Alarm pending flag sets regardless of alarm mask.
// - Writing status with bit 1 high clears alarm flag; zero leaves it.
// - With clock off, mode, status and the three event registers stay accessible; only alarm day is blocked.
// - Day mode zero ignores day field in alarm compare; one compares it.
module rtc_flags
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic second_tick_i,
   input wire logic alarm_time_match_i,
   input wire logic [4:0] current_day_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   output logic rtc_irq_o,
   output logic event_irq_o,
   output logic rtc_clock_on_o,
   output logic alarm_day_compare_mode_o,
   output logic [4:0] alarm_day_field_o
);

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] mode_r;
   logic valid_r;
   logic alarm_pend_r;
   logic per_pend_r;
   logic [1:0] evt_stat_r;
   logic [1:0] evt_en_r;
   logic [4:0] alarm_day_r;
   logic [4:0] cur_day_r;
   logic [1:0] tick_sync_r;
   logic [1:0] match_sync_r;
   logic tick_d_r;
   logic match_d_r;
   rtc_flags_pkg::wb_req_s req;
   rtc_flags_pkg::rtc_evt_s evt;
   logic take;
   logic wr;
   logic blocked;
   logic alarm_hit;
   logic per_clr;
   logic alarm_clr;
   logic [4:0] day_meta_r;
   logic per_irq_nxt;
   logic alarm_irq_nxt;

   // Writable mode bits; the pause and reserved bits always read zero
   localparam logic [7:0] mode_wmask = 8'h8b;

   // Classify an index as always reachable, even with the clock off
   function automatic logic is_open(input logic [3:0] idx);
      is_open = (idx == rtc_flags_pkg::mode_idx) ||
                (idx == rtc_flags_pkg::status_idx) ||
                (idx == rtc_flags_pkg::irq_stat_idx) ||
                (idx == rtc_flags_pkg::irq_en_idx) ||
                (idx == rtc_flags_pkg::irq_clr_idx);
   endfunction

   // Status byte as software reads it; reserved bits read zero
   function automatic logic [7:0] status_word(input logic v, input logic a,
                                              input logic p);
      status_word = {v, 5'h00, a, p};
   endfunction

   // ************************************************************
   // Bus decode
   // ************************************************************
   // One request per handshake: no take in the cycle we answer.
   // A master that holds stb past ack is taken again once ack
   // falls, so masters must drop stb for a cycle between requests.
   assign req = '{idx: adr_i[5:2], we: we_i, sel0: sel_i[0],
                  dat: dat_i[7:0]};
   assign take = cyc_i && stb_i && !ack_o && !err_o;
   assign blocked = !mode_r[rtc_flags_pkg::mode_on_bit] &&
                    !is_open(req.idx);
   assign wr = take && req.we && req.sel0 && !blocked;
   assign per_clr = wr && (req.idx == rtc_flags_pkg::status_idx) &&
                    req.dat[rtc_flags_pkg::stat_per_bit];
   assign alarm_clr = wr && (req.idx == rtc_flags_pkg::status_idx) &&
                      req.dat[rtc_flags_pkg::stat_alarm_bit];

   // Synchronise the core's events; first stage read by second only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_sync_r <= 2'h0;
         match_sync_r <= 2'h0;
         tick_d_r <= 1'b0;
         match_d_r <= 1'b0;
      end
      else if (ce_i)
      begin
         tick_sync_r <= {tick_sync_r[0], second_tick_i};
         match_sync_r <= {match_sync_r[0], alarm_time_match_i};
         tick_d_r <= tick_sync_r[1];
         match_d_r <= match_sync_r[1];
      end
   end

   // Day bus through two stages; the core holds it steady around a match
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         day_meta_r <= 5'h00;
         cur_day_r <= 5'h00;
      end
      else if (ce_i)
      begin
         day_meta_r <= current_day_i;
         cur_day_r <= day_meta_r;
      end
   end

   // Rising edges become one-cycle events; day compare per mode
   assign alarm_hit = !mode_r[rtc_flags_pkg::mode_daycmp_bit] ||
                      (cur_day_r == alarm_day_r);
   assign evt.second = tick_sync_r[1] && !tick_d_r;
   assign evt.alarm = match_sync_r[1] && !match_d_r && alarm_hit;

   // ************************************************************
   // Registers written by software
   // ************************************************************
   // Mode register and alarm day field
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_r <= rtc_flags_pkg::mode_rst;
         alarm_day_r <= rtc_flags_pkg::alarm_day_rst;
      end
      else if (ce_i && wr)
      begin
         if (req.idx == rtc_flags_pkg::mode_idx)
            mode_r <= req.dat & mode_wmask; // Reserved bits stay zero
         if (req.idx == rtc_flags_pkg::alarm_idx)
            alarm_day_r <= req.dat[4:0];
      end
   end

   // Validity flag: cleared by hard reset, else software's value
   // Hard reset or a software write of zero clears it; the clock enable freezes it like all else
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         valid_r <= 1'b0;
      else if (ce_i && wr && (req.idx == rtc_flags_pkg::status_idx))
         valid_r <= req.dat[rtc_flags_pkg::stat_valid_bit];
   end

   // Pending flags ignore masks; a set in the clear cycle wins
   // An event in the clear cycle survives, so a clear never drops a second
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alarm_pend_r <= 1'b0;
         per_pend_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (evt.alarm)
            alarm_pend_r <= 1'b1;
         else if (alarm_clr)
            alarm_pend_r <= 1'b0;
         if (evt.second)
            per_pend_r <= 1'b1;
         else if (per_clr)
            per_pend_r <= 1'b0;
      end
   end

   // ************************************************************
   // Event interrupt registers
   // ************************************************************
   // Event enable, plain read and write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         evt_en_r <= rtc_flags_pkg::irq_rst;
      else if (ce_i && wr && (req.idx == rtc_flags_pkg::irq_en_idx))
         evt_en_r <= req.dat[1:0];
   end

   // Sticky events: bit 0 second, bit 1 alarm; write-one clear, set wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         evt_stat_r <= rtc_flags_pkg::irq_rst;
      else if (ce_i)
      begin
         if (wr && (req.idx == rtc_flags_pkg::irq_clr_idx))
            evt_stat_r <= (evt_stat_r & ~req.dat[1:0]) |
                          {evt.alarm, evt.second};
         else
            evt_stat_r <= evt_stat_r | {evt.alarm, evt.second};
      end
   end

   // ************************************************************
   // Outputs, all registered
   // ************************************************************
   // Bus answer one cycle after the request; blocked or unmapped -> err
   // dat_o holds between answers; only ack or err qualifies it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         if (take)
         begin
            if (blocked || req.idx > rtc_flags_pkg::alarm_idx)
               err_o <= 1'b1;
            else
               ack_o <= 1'b1;
            case (req.idx)
               rtc_flags_pkg::mode_idx:
                  dat_o <= {24'h0, mode_r};
               rtc_flags_pkg::status_idx:
                  dat_o <= {24'h0, status_word(valid_r, alarm_pend_r,
                                               per_pend_r)};
               rtc_flags_pkg::irq_stat_idx:
                  dat_o <= {30'h0, evt_stat_r};
               rtc_flags_pkg::irq_en_idx:
                  dat_o <= {30'h0, evt_en_r};
               rtc_flags_pkg::alarm_idx:
                  dat_o <= {27'h0, alarm_day_r};
               default:
                  dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Masked interrupt causes; masks gate only the line, never the flags
   assign per_irq_nxt = per_pend_r &&
                        mode_r[rtc_flags_pkg::mode_per_msk_bit];
   assign alarm_irq_nxt = alarm_pend_r &&
                          mode_r[rtc_flags_pkg::mode_alarm_msk_bit];

   // Interrupt lines track flags and masks one cycle later
   // Registered so the line is glitch free; costs one cycle of latency
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rtc_irq_o <= 1'b0;
         event_irq_o <= 1'b0;
      end
      else if (ce_i)
      begin
         rtc_irq_o <= per_irq_nxt || alarm_irq_nxt;
         event_irq_o <= |(evt_stat_r & evt_en_r);
      end
   end

   // Mode fields out to the counting core
   // Core sees mode one cycle after a write; harmless at this clock rate
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rtc_clock_on_o <= 1'b0;
         alarm_day_compare_mode_o <= 1'b0;
         alarm_day_field_o <= rtc_flags_pkg::alarm_day_rst;
      end
      else if (ce_i)
      begin
         rtc_clock_on_o <= mode_r[rtc_flags_pkg::mode_on_bit];
         alarm_day_compare_mode_o <= mode_r[rtc_flags_pkg::mode_daycmp_bit];
         alarm_day_field_o <= alarm_day_r;
      end
   end

endmodule

/* File: verif/rtc_flags_assertions.sv */
// Port-level concurrent checks for the RTC flag block
`timescale 1ns/1ps
module rtc_flags_assertions
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [5:0] adr_i,
   input wire logic second_tick_i,
   input wire logic alarm_time_match_i,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic rtc_irq_o,
   input wire logic event_irq_o,
   input wire logic rtc_clock_on_o
);
   logic [3:0] quiet_r;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Cycles since bus or event activity; an irq may only rise soon after
   always_ff @(posedge clk_i)
      if (rst_i || cyc_i || second_tick_i || alarm_time_match_i)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;

   // ****************************************
   // Bus steps, freeze, reset and irq causes
   // ****************************************
   sequence s_taken;
      cyc_i && stb_i && ce_i && !ack_o && !err_o;
   endsequence
   sequence s_answer;
      ack_o || err_o;
   endsequence
   property p_answer;
      s_taken |=> s_answer;
   endproperty
   property p_bad;
      s_taken ##0 (adr_i[5:2] > 4'h5) |=> err_o && !ack_o;
   endproperty
   property p_blocked;
      s_taken ##0 (adr_i[5:2] == 4'h5 && !rtc_clock_on_o) |=> err_o;
   endproperty
   property p_open;
      s_taken ##0 (adr_i[5:2] < 4'h5 || adr_i[5:2] == 4'h5 && rtc_clock_on_o)
         |=> ack_o && !err_o;
   endproperty
   property p_pulse;
      s_answer ##0 ce_i |=> !ack_o && !err_o;
   endproperty
   property p_freeze;
      !ce_i |=> $stable(rtc_irq_o) && $stable(event_irq_o) && $stable(ack_o);
   endproperty
   property p_reset;
      disable iff (1'b0)
      rst_i |=> !ack_o && !err_o && !rtc_irq_o && !event_irq_o;
   endproperty
   property p_irq_cause;
      $rose(rtc_irq_o) |-> quiet_r < 4'h6;
   endproperty
   property p_ev_cause;
      $rose(event_irq_o) |-> quiet_r < 4'h6;
   endproperty

   a_answer: assert property (p_answer) else $error("no bus answer");
   a_bad: assert property (p_bad) else $error("unmapped not refused");
   a_blocked: assert property (p_blocked) else $error("not blocked");
   a_open: assert property (p_open) else $error("open access refused");
   a_pulse: assert property (p_pulse) else $error("answer too long");
   a_freeze: assert property (p_freeze) else $error("moved while frozen");
   a_reset: assert property (p_reset) else $error("reset state");
   a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
   a_ev_cause: assert property (p_ev_cause) else $error("event irq cause");
endmodule

bind rtc_flags rtc_flags_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i),
   .second_tick_i(second_tick_i), .alarm_time_match_i(alarm_time_match_i),
   .ack_o(ack_o), .err_o(err_o), .rtc_irq_o(rtc_irq_o),
   .event_irq_o(event_irq_o), .rtc_clock_on_o(rtc_clock_on_o));

/* File: verif/rtc_flags_bench.sv */
// Self-checking bench with a behavioural model of the RTC flag block
`timescale 1ns/1ps
module rtc_flags_bench;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [5:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o;
   logic second_tick_i = 0, alarm_time_match_i = 0, e;
   logic [4:0] current_day_i = 0, alarm_day_field_o;
   logic ack_o, err_o, rtc_irq_o, event_irq_o, rtc_clock_on_o, dmode;
   logic [7:0] q, d;
   int failures = 0, check_count = 0, cyc_n = 0, seed = 32'h1469cee2;
   int mode = 0, valid = 0, alm = 0, per = 0, evs = 0, eve = 0, aday = 0;
   int cur = 0;

   rtc_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .second_tick_i(second_tick_i),
      .alarm_time_match_i(alarm_time_match_i), .current_day_i(current_day_i),
      .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .rtc_irq_o(rtc_irq_o),
      .event_irq_o(event_irq_o), .rtc_clock_on_o(rtc_clock_on_o),
      .alarm_day_compare_mode_o(dmode), .alarm_day_field_o(alarm_day_field_o));

   // 20 MHz clock
   initial
      forever #25 clk_i = ~clk_i;

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic chk(string nm, logic [7:0] s, logic [7:0] x);
      check_count++;
      if (s !== x)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Classic cycle; waits for the answer, only the timeout ends a hang
   task automatic wb(int i, logic w, logic s, logic [7:0] v);
      {cyc_i, stb_i, we_i, sel_i, adr_i} <= {2'b11, w, 3'h7, s, 6'(i * 4)};
      dat_i <= {24'h0, v};
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1);
      q = dat_o[7:0];
      e = err_o;
      {cyc_i, stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask

   function automatic logic [7:0] rexp(int i);
      case (i)
         0: return 8'(mode);
         1: return 8'(valid * 128 + alm * 2 + per);
         2: return 8'(evs);
         3: return 8'(eve);
         5: return 8'(aday);
         default: return 8'h00;
      endcase
   endfunction

   task automatic st;
      chk("rtc_irq", 8'(rtc_irq_o), 8'(per & mode[0] | alm & mode[1]));
      chk("event_irq", 8'(event_irq_o), 8'((evs & eve) != 0));
      chk("clock_on", 8'(rtc_clock_on_o), 8'(mode[7]));
      chk("day_mode", 8'(dmode), 8'(mode[3]));
      chk("day", 8'(alarm_day_field_o), 8'(aday));
   endtask

   task automatic rd(int i);
      int b;
      b = i > 5 || (i == 5 && mode[7] == 0);
      wb(i, 0, 1, 8'h00);
      chk("read_err", 8'(e), 8'(b));
      if (b == 0)
         chk("read_data", q, rexp(i));
   endtask

   // Model only moves on an accepted write with the low lane selected
   task automatic wr(int i, logic [7:0] v, logic s = 1);
      int b;
      b = i > 5 || (i == 5 && mode[7] == 0);
      wb(i, 1, s, v);
      chk("write_err", 8'(e), 8'(b));
      if (s && b == 0)
      begin
         if (i == 0)
            mode = v & 8'h8b;
         if (i == 1)
         begin
            valid = v[7];
            alm &= !v[1];
            per &= !v[0];
         end
         if (i == 3)
            eve = v[1:0];
         if (i == 4)
            evs &= ~v[1:0];
         if (i == 5)
            aday = v[4:0];
      end
      st;
   endtask

   // One second tick or alarm match as a level pulse of two cycles
   task automatic ev(logic a);
      int ok;
      {alarm_time_match_i, second_tick_i} <= {a, !a};
      repeat (2) @(posedge clk_i);
      {second_tick_i, alarm_time_match_i} <= 2'b00;
      repeat (6) @(posedge clk_i);
      ok = a && (mode[3] == 0 || cur == aday);
      per |= !a;
      alm |= ok;
      evs |= !a + 2 * ok;
      st;
   endtask

   // Cycle ceiling far above the few hundred cycles the run needs
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 3000)
      begin
         failures++;
         give_verdict;
      end
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      for (int i = 0; i < 7; i++)
         rd(i);
      ev(0);
      rd(1);
      wr(1, 8'h80);
      rd(1);
      ev(1);
      wr(1, 8'h81);
      rd(1);
      wr(1, 8'h82, 0);
      rd(1);
      wr(1, 8'h02);
      rd(1);
      wr(0, 8'h03);
      ev(0);
      ev(1);
      wr(1, 8'h03);
      wr(3, 8'h03);
      ev(0);
      rd(2);
      wr(3, 8'h01);
      wr(4, 8'h01);
      rd(2);
      rd(4);
      ce_i <= 0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1;
      wr(0, 8'h88);
      d = 8'($random(seed));
      wr(5, d);
      rd(5);
      for (int k = 1; k >= 0; k--)
      begin
         cur = aday ^ k;
         current_day_i <= 5'(cur);
         ev(1);
         rd(1);
         wr(1, 8'h03);
      end
      wr(0, 8'h80);
      wr(6, 8'h00);
      repeat (8)
      begin
         d = 8'($random(seed));
         cur = d[4:0];
         current_day_i <= d[4:0];
         wr(1, d);
         ev(d[5]);
         rd(1);
      end
      give_verdict;
   end
endmodule
